// [hdl/acs_pkg.sv]
// package: register map, field layout and types of the conversion sequencer
package acs_pkg;
    // bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    // register byte addresses
    localparam logic [4:0] OFS_CTRL_FIRST = 5'h00;
    localparam logic [4:0] OFS_CTRL_SECOND = 5'h04;
    localparam logic [4:0] OFS_RESULT_HIGH = 5'h08;
    localparam logic [4:0] OFS_RESULT_LOW = 5'h0C;
    localparam logic [4:0] OFS_BANDGAP = 5'h10;
    localparam logic [4:0] OFS_IRQ_CTRL = 5'h14;
    // converter_control_first fields
    localparam int CF_START = 7;
    localparam int CF_BUSY = 6;
    localparam int CF_POWER = 5;
    localparam int CF_FORMAT = 4;
    localparam int CF_CHAN_LSB = 0;
    // converter_control_second fields
    localparam int CS_SRC_LSB = 5;
    localparam int CS_REF_LSB = 3;
    localparam int CS_CLK_LSB = 0;
    // interrupt control fields
    localparam int IC_GLOBAL = 0;
    localparam int IC_ENABLE = 1;
    localparam int IC_REQUEST = 2;
    // bandgap control field
    localparam int BG_ENABLE = 0;
    // values after reset
    localparam logic [7:0] RST_CTRL_FIRST = 8'h00;
    localparam logic [7:0] RST_CTRL_SECOND = 8'h00;
    localparam logic [7:0] RST_BANDGAP = 8'h00;
    localparam logic [11:0] RST_RESULT = 12'h000;
    // conversion timing in converter clock cycles
    localparam logic [3:0] SAMPLE_TICKS = 4'h4;
    localparam logic [3:0] CONVERT_TICKS = 4'hC;
    localparam logic [3:0] LAST_TICK = 4'(SAMPLE_TICKS + CONVERT_TICKS - 4'h1);
    // encodings
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [2:0] SRC_EXTERNAL = 3'h0;
    localparam logic [2:0] SRC_INT_FIRST = 3'h1;
    localparam logic [2:0] SRC_INT_LAST = 3'h4;

    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARMED = 4'h2,
        ST_SAMPLE = 4'h4,
        ST_CONVERT = 4'h8
    } acs_state_t;

    // routing handed to the analog input multiplexer
    typedef struct packed {
        logic ext_connect;     // external pin joined to converter
        logic [2:0] ext_chan;  // external channel number
        logic [2:0] int_src;   // internal signal code, 0 when none
        logic ref_supply;      // 1 analog supply, 0 reference pin
    } acs_route_t;
endpackage

// [hdl/acs_core.sv]
// file: conversion sequencer with register slave and analog control outputs
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - bandgap output driven when its enable bit is set, floating otherwise
// - bandgap control upper seven bits read zero
// - four converter clocks sampling then twelve converting per result
// - conversion runs on its own; the bus is never held by it
// - format bit arranges twelve result bits over high and low bytes
// - interrupt reaches processor only with global and converter enables
// - busy high during conversion, low when result valid
// - power enable low switches converter circuitry off
// - twelve-bit unsigned result, step is reference over 4096
// - completion sets request flag; software clears it
// - clock select divides system clock by two to the field value
// - reference code 01 picks analog supply, others reference pin
// - sources 0,5-7 route pins 0-7; 1-4 internal with codes 8-15
module acs_core
    import acs_pkg::*;
(
    input wire logic mclk,                              // system clock
    input wire logic sys_rst,                           // async reset
    input wire logic clk_en,                            // freezes state low
    input wire logic [acs_pkg::ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read,                          // read request
    input wire logic avs_write,                         // write request
    input wire logic [acs_pkg::DATA_W-1:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable,              // byte lanes
    output logic [acs_pkg::DATA_W-1:0] avs_readdata,    // read data
    output logic avs_waitrequest,                       // stall
    input wire logic [11:0] core_result,                // converter code
    output logic conv_power_on,                         // core powered
    output logic conv_sample,                           // sample phase
    output logic conv_run,                              // convert phase
    output acs_pkg::acs_route_t conv_route,             // mux routing
    output logic bandgap_drive,                         // bandgap drives
    output logic conv_busy,                             // busy flag copy
    output logic conv_irq                               // to processor
);
    import acs_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers and state
    logic start_bit;
    logic start_prev;
    logic power_enable;
    logic format_sel;
    logic [3:0] chan_sel;
    logic [2:0] src_sel;
    logic [1:0] ref_sel;
    logic [2:0] clk_sel;
    logic bandgap_output_enable;
    logic global_ie;
    logic conv_ie;
    logic irq_request;
    logic [7:0] result_high;
    logic [7:0] result_low;
    logic [6:0] div_cnt;
    logic [3:0] tick_cnt;
    acs_state_t state;
    acs_state_t next_state;

    ////////////////////////////////////////////////////////////////////
    // bus decode
    wire bus_req = avs_read | avs_write;
    wire wr_take = avs_write & ~avs_waitrequest & avs_byteenable[0];
    wire wr_first = wr_take & (avs_address == OFS_CTRL_FIRST);
    wire wr_second = wr_take & (avs_address == OFS_CTRL_SECOND);
    wire wr_bandgap = wr_take & (avs_address == OFS_BANDGAP);
    wire wr_irq = wr_take & (avs_address == OFS_IRQ_CTRL);
    wire [7:0] wbyte = avs_writedata[7:0];

    // read mux, unmapped reads return zero
    wire busy_now = (state == ST_SAMPLE) | (state == ST_CONVERT);
    wire [7:0] rd_first = {start_bit, busy_now, power_enable, format_sel,
                           chan_sel};
    wire [7:0] rd_second = {src_sel, ref_sel, clk_sel};
    wire [7:0] rd_bandgap = {7'h00, bandgap_output_enable};
    wire [7:0] rd_irq = {5'h00, irq_request, conv_ie, global_ie};
    wire [7:0] rd_byte =
        (avs_address == OFS_CTRL_FIRST) ? rd_first :
        (avs_address == OFS_CTRL_SECOND) ? rd_second :
        (avs_address == OFS_RESULT_HIGH) ? result_high :
        (avs_address == OFS_RESULT_LOW) ? result_low :
        (avs_address == OFS_BANDGAP) ? rd_bandgap :
        (avs_address == OFS_IRQ_CTRL) ? rd_irq : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // converter clock divider
    // divide by two to the power of select
    wire [7:0] div_span = 8'h01 << clk_sel;
    wire [6:0] div_mask = 7'(div_span[6:0] - 7'h01);
    wire adc_tick = (div_cnt & div_mask) == div_mask;

    ////////////////////////////////////////////////////////////////////
    // start edges and sequencer decisions
    wire start_rise = start_bit & ~start_prev;
    wire start_fall = ~start_bit & start_prev;
    wire in_conv = busy_now;
    wire last_tick = in_conv & adc_tick & (tick_cnt == LAST_TICK);
    wire sample_end = adc_tick & (tick_cnt == 4'(SAMPLE_TICKS - 4'h1));

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_rise) begin
                    next_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (start_fall) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (start_rise) begin
                    next_state = ST_ARMED;
                end else if (sample_end) begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (start_rise) begin
                    next_state = ST_ARMED;
                end else if (last_tick) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!power_enable) begin
            next_state = ST_IDLE;
        end
    end

    wire conv_done = last_tick & power_enable & ~start_rise;
    wire conv_begin = (next_state == ST_SAMPLE) & (state == ST_ARMED);

    wire [7:0] next_high = format_sel ? {4'h0, core_result[11:8]}
                                      : core_result[11:4];
    wire [7:0] next_low = format_sel ? core_result[7:0]
                                     : {core_result[3:0], 4'h0};

    wire next_request = conv_done |
                        (wr_irq ? (irq_request & wbyte[IC_REQUEST])
                                : irq_request);
    wire next_gie = wr_irq ? wbyte[IC_GLOBAL] : global_ie;
    wire next_cie = wr_irq ? wbyte[IC_ENABLE] : conv_ie;

    // routing from source and channel codes
    wire src_internal = (src_sel >= SRC_INT_FIRST) &
                        (src_sel <= SRC_INT_LAST);
    wire chan_external = ~chan_sel[3];
    acs_route_t next_route;
    assign next_route.ext_connect = chan_external & power_enable;
    assign next_route.ext_chan = chan_sel[2:0];
    assign next_route.int_src = src_internal ? src_sel : SRC_EXTERNAL;
    // only code 01 selects the supply
    assign next_route.ref_supply = (ref_sel == REF_SUPPLY);

    ////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then the access completes
    // never stalled by a running conversion
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
        end else if (clk_en) begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (bus_req & avs_waitrequest) begin
                avs_readdata <= {24'h000000, rd_byte};
            end
        end
    end

    // first control register, start bit edge history
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {start_bit, power_enable, format_sel} <= 3'b000;
            chan_sel <= RST_CTRL_FIRST[3:0];
            start_prev <= 1'b0;
        end else if (clk_en) begin
            start_prev <= start_bit;
            if (wr_first) begin
                start_bit <= wbyte[CF_START];
                power_enable <= wbyte[CF_POWER];
                format_sel <= wbyte[CF_FORMAT];
                chan_sel <= wbyte[CF_CHAN_LSB +: 4];
            end
        end
    end

    // second control register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {src_sel, ref_sel, clk_sel} <= RST_CTRL_SECOND;
        end else if (clk_en && wr_second) begin
            src_sel <= wbyte[CS_SRC_LSB +: 3];
            ref_sel <= wbyte[CS_REF_LSB +: 2];
            clk_sel <= wbyte[CS_CLK_LSB +: 3];
        end
    end

    // bandgap enable and interrupt control
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bandgap_output_enable <= RST_BANDGAP[BG_ENABLE];
            {global_ie, conv_ie, irq_request} <= 3'b000;
        end else if (clk_en) begin
            if (wr_bandgap) begin
                bandgap_output_enable <= wbyte[BG_ENABLE];
            end
            global_ie <= next_gie;
            conv_ie <= next_cie;
            irq_request <= next_request;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer state, divider and tick counters
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            div_cnt <= 7'h00;
            tick_cnt <= 4'h0;
        end else if (clk_en) begin
            state <= next_state;
            if (conv_begin || !in_conv) begin
                div_cnt <= 7'h00;
                tick_cnt <= 4'h0;
            end else begin
                div_cnt <= 7'(div_cnt + 7'h01);
                if (adc_tick) begin
                    tick_cnt <= 4'(tick_cnt + 4'h1);
                end
            end
        end
    end

    // both result bytes load together at completion
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            result_high <= RST_RESULT[11:4];
            result_low <= {RST_RESULT[3:0], 4'h0};
        end else if (clk_en && conv_done) begin
            result_high <= next_high;
            result_low <= next_low;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs toward the analog side and processor
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_power_on <= 1'b0;
            conv_sample <= 1'b0;
            conv_run <= 1'b0;
            conv_route <= '0;
            bandgap_drive <= 1'b0;
            conv_busy <= 1'b0;
            conv_irq <= 1'b0;
        end else if (clk_en) begin
            conv_power_on <= power_enable;
            conv_sample <= next_state == ST_SAMPLE;
            conv_run <= next_state == ST_CONVERT;
            conv_route <= next_route;
            bandgap_drive <= bandgap_output_enable;
            conv_busy <= (next_state == ST_SAMPLE) |
                         (next_state == ST_CONVERT);
            conv_irq <= next_request & next_gie & next_cie;
        end
    end
endmodule

`default_nettype wire

// [dv/acs_core_chk.sv]
// checker: bus and sequencing properties of the converter core
`timescale 1ns/1ps
`default_nettype none
module acs_core_chk
    import acs_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic sys_rst, // reset
    input wire logic clk_en, // clock enable
    input wire logic [acs_pkg::ADDR_W-1:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [acs_pkg::DATA_W-1:0] avs_writedata, // wdata
    input wire logic [3:0] avs_byteenable, // lanes
    input wire logic [acs_pkg::DATA_W-1:0] avs_readdata, // rdata
    input wire logic avs_waitrequest, // stall
    input wire logic conv_power_on, // powered
    input wire logic conv_sample, // sampling
    input wire logic conv_run, // converting
    input wire acs_pkg::acs_route_t conv_route, // routing
    input wire logic bandgap_drive, // bandgap on
    input wire logic conv_busy, // busy
    input wire logic conv_irq // interrupt
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [15:0] samp_n;
    logic [15:0] run_n;
    ////////////////////////////////////////
    // completed accesses of interest
    wire done_acc = !avs_waitrequest && clk_en;
    wire bg_wr = done_acc && avs_write && avs_byteenable[0]
        && avs_address == OFS_BANDGAP;
    wire irq_wr = done_acc && avs_write && avs_address == OFS_IRQ_CTRL;
    // phase lengths within one busy span
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            samp_n <= 16'h0000;
            run_n <= 16'h0000;
        end else if (clk_en) begin
            samp_n <= !conv_busy ? 16'h0000 : samp_n + 16'(conv_sample);
            run_n <= !conv_busy ? 16'h0000 : run_n + 16'(conv_run);
        end
    end
    ////////////////////////////////////////
    bus_answer_a:
        assert property ((avs_read || avs_write) && avs_waitrequest
            && clk_en |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
    wait_pulse_a:
        assert property (done_acc |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    bg_drive_a:
        assert property (bg_wr |-> ##2
            bandgap_drive == $past(avs_writedata[0], 2))
        else $error("bandgap drive does not follow enable");
    bg_zero_a:
        assert property (done_acc && avs_read
            && avs_address == OFS_BANDGAP |-> avs_readdata[7:1] == 7'h00)
        else $error("bandgap upper bits not zero");
    phase_ratio_a:
        assert property ($fell(conv_run) |-> run_n == 3 * samp_n)
        else $error("convert phase not three times sample phase");
    busy_start_a:
        assert property ($rose(conv_busy) |-> conv_sample && !conv_run)
        else $error("busy rose without sampling");
    busy_cover_a:
        assert property (conv_sample || conv_run |-> conv_busy)
        else $error("phase active while not busy");
    run_follow_a:
        assert property ($fell(conv_sample) |-> conv_run)
        else $error("conversion did not follow sampling");
    busy_end_a:
        assert property ($fell(conv_run) |-> ##[0:2] !conv_busy)
        else $error("busy stayed high after conversion");
    irq_cause_a:
        assert property ($rose(conv_irq) |-> $past(conv_busy) || $past(irq_wr)
            || $past(irq_wr, 2))
        else $error("interrupt rose without cause");
    ext_power_a:
        assert property (conv_route.ext_connect |-> conv_power_on)
        else $error("pin routed while unpowered");
endmodule
`default_nettype wire

// [dv/acs_conv_model.sv]
// converter core model: returns a routing-derived code while busy
`timescale 1ns/1ps
`default_nettype none
module acs_conv_model
    import acs_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic conv_power_on, // core powered
    input wire logic conv_busy, // conversion running
    input wire acs_pkg::acs_route_t conv_route, // mux routing
    output logic [11:0] core_result // code to sequencer
);
    logic flip = 1'b0;
    ////////////////////////////////////////
    // idle pattern changes every cycle
    always @(posedge mclk) begin
        flip <= ~flip;
    end
    assign core_result = (conv_busy && conv_power_on) ?
        {4'hA, conv_route} : {12{flip}};
endmodule
`default_nettype wire

// [dv/acs_core_bench.sv]
// testbench: register access and conversion runs of the converter core
`timescale 1ns/1ps
`default_nettype none
module acs_core_bench;
    import acs_pkg::*;
    localparam int SETTLE = 20; // settling wait, value arbitrary
    typedef struct {
        logic [4:0] a;
        logic [7:0] d;
        logic [3:0] be;
        logic [7:0] q;
        logic bg;
    } acs_row_t;
    logic mclk, sys_rst, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic conv_power_on, conv_sample, conv_run, bandgap_drive;
    logic conv_busy, conv_irq, intl;
    logic [11:0] core_result, code;
    logic [7:0] cf, cs, hi, lo;
    acs_route_t conv_route, route;
    int error_cnt = 0;
    int total_checks = 0;
    int busy_len = 0;
    int last_len = 0;
    int n;
    acs_row_t rows [7] = '{
        '{OFS_BANDGAP, 8'hFF, 4'hF, 8'h01, 1'b1},
        '{OFS_BANDGAP, 8'hFE, 4'hF, 8'h00, 1'b0},
        '{OFS_BANDGAP, 8'h01, 4'hE, 8'h00, 1'b0},
        '{OFS_CTRL_SECOND, 8'hA5, 4'hF, 8'hA5, 1'b0},
        '{5'h18, 8'h5A, 4'hF, 8'h00, 1'b0},
        '{OFS_RESULT_LOW, 8'hFF, 4'hF, 8'h00, 1'b0},
        '{OFS_IRQ_CTRL, 8'h07, 4'hF, 8'h03, 1'b0}};
    ////////////////////////////////////////
    acs_core acs_core_inst (.mclk, .sys_rst, .clk_en, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .core_result, .conv_power_on,
        .conv_sample, .conv_run, .conv_route, .bandgap_drive, .conv_busy,
        .conv_irq);
    acs_conv_model acs_conv_model_inst (.mclk, .conv_power_on, .conv_busy,
        .conv_route, .core_result);
    // clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // busy span of the latest conversion
    always @(posedge mclk) begin
        if (conv_busy === 1'b1) begin
            busy_len <= busy_len + 1;
        end else if (busy_len != 0) begin
            last_len <= busy_len;
            busy_len <= 0;
        end
    end
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one bus access held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [7:0] d, input logic [3:0] be);
        int k;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        check("bus answer", 32'(avs_waitrequest), 0);
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("[ERR] watchdog expected done seen hang");
        finish_test();
    end
    ////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        hi = 8'h00;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1 check("idle busy", {avs_waitrequest, conv_busy}, 2'h2);
        check("idle irq", conv_irq, 0);
        check("idle power", {bandgap_drive, conv_power_on}, 0);
        check("idle route", conv_route, 0);
        for (int a = 0; a < 24; a += 4) begin
            bus(1'b0, 5'(a), 8'h00, 4'hF);
            check("reset value", rd, 32'h00000000);
        end
        $display("reset test done");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d, rows[i].be);
            bus(1'b0, rows[i].a, 8'h00, 4'hF);
            check("reg read", rd, {24'h000000, rows[i].q});
            check("bandgap", bandgap_drive, rows[i].bg);
            $display("row %0d done", i);
        end
        // power up, then one conversion per clock select and source
        // power on first
        bus(1'b1, OFS_CTRL_FIRST, 8'h20, 4'hF);
        repeat (SETTLE) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            intl = i >= 1 && i <= 4;
            cf = {3'b001, i[0], intl ? 4'(8 + i) : 4'(i)};
            cs = {3'(i), 2'(i), 3'(i)};
            bus(1'b1, OFS_IRQ_CTRL, {6'h00, i[2:1]}, 4'hF);
            if (intl) bus(1'b1, OFS_CTRL_FIRST, cf, 4'hF);
            bus(1'b1, OFS_CTRL_SECOND, cs, 4'hF);
            if (!intl) bus(1'b1, OFS_CTRL_FIRST, cf, 4'hF);
            route = '{!intl, 3'(i), intl ? 3'(i) : 3'h0, i[1:0] == 2'h1};
            repeat (2) @(posedge mclk);
            #1 check("routing", conv_route, route);
            bus(1'b1, OFS_CTRL_FIRST, cf | 8'h80, 4'hF);
            bus(1'b1, OFS_CTRL_FIRST, cf, 4'hF);
            #1 check("busy early", conv_busy, 0);
            @(posedge mclk);
            #1 check("busy up", {conv_busy, conv_sample}, 2'h3);
            bus(1'b0, OFS_RESULT_HIGH, 8'h00, 4'hF);
            check("result kept", rd[7:0], hi);
            bus(1'b0, OFS_CTRL_FIRST, 8'h00, 4'hF);
            check("busy bit", rd[7:0], cf | 8'h40);
            n = 0;
            do begin
                bus(1'b0, OFS_CTRL_FIRST, 8'h00, 4'hF);
                n++;
            end while (rd[6] !== 1'b0 && n < 1000);
            check("busy clear", rd[7:0], cf);
            check("busy span", last_len >= (16 << i)
                && last_len <= (17 << i) + 2, 1);
            code = {4'hA, route};
            hi = i[0] ? {4'h0, code[11:8]} : code[11:4];
            lo = i[0] ? code[7:0] : {code[3:0], 4'h0};
            bus(1'b0, OFS_RESULT_HIGH, 8'h00, 4'hF);
            check("result high", rd, {24'h000000, hi});
            bus(1'b0, OFS_RESULT_LOW, 8'h00, 4'hF);
            check("result low", rd, {24'h000000, lo});
            check("irq", conv_irq, i[1] & i[2]);
            bus(1'b0, OFS_IRQ_CTRL, 8'h00, 4'hF);
            check("flag", rd[7:0], {5'h01, i[2:1]});
            $display("conversion %0d done", i);
        end
        // clock enable low freezes a running conversion for 11 edges
        bus(1'b1, OFS_CTRL_SECOND, 8'h00, 4'hF);
        bus(1'b1, OFS_CTRL_FIRST, cf | 8'h80, 4'hF);
        bus(1'b1, OFS_CTRL_FIRST, cf, 4'hF);
        repeat (3) @(posedge mclk);
        clk_en <= 1'b0;
        repeat (10) @(posedge mclk);
        #1 check("frozen", {conv_busy, conv_sample}, 2'h3);
        @(posedge mclk);
        clk_en <= 1'b1;
        n = 0;
        do begin
            bus(1'b0, OFS_CTRL_FIRST, 8'h00, 4'hF);
            n++;
        end while (rd[6] !== 1'b0 && n < 1000);
        check("freeze span", last_len >= 27 && last_len <= 29, 1);
        $display("freeze test done");
        bus(1'b1, OFS_IRQ_CTRL, 8'h00, 4'hF);
        bus(1'b1, OFS_CTRL_FIRST, 8'h03, 4'hF);
        repeat (2) @(posedge mclk);
        check("power off", {conv_power_on, conv_route.ext_connect,
            conv_irq}, 3'b000);
        $display("power off test done");
        finish_test();
    end
endmodule
bind acs_core acs_core_chk acs_core_chk_inst (.mclk, .sys_rst, .clk_en,
    .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .conv_power_on, .conv_sample, .conv_run, .conv_route,
    .bandgap_drive, .conv_busy, .conv_irq);
`default_nettype wire
